/* File: bcd_stopwatch_timer.sv */
`timescale 1ns/1ps

module bcd_stopwatch_timer
    import stopwatch_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_DIV
)
(
    input wire logic REF_CLK, // 200 MHz clock
    input wire logic SRST, // Synchronous reset, active high
    input wire logic CLK_EN, // Freezes all state while low
    input wire logic [stopwatch_pkg::ADDR_W-1:0] AVS_ADDRESS, // Byte address
    input wire logic AVS_READ, // Read request
    input wire logic AVS_WRITE, // Write request
    input wire logic [31:0] AVS_WRITEDATA, // Write data
    input wire logic [3:0] AVS_BYTEENABLE, // Byte enables
    output logic [31:0] AVS_READDATA, // Read data
    output logic AVS_WAITREQUEST, // Wait request
    output logic HEAVY_LOAD_SELECT, // Regulator heavy-load mode
    output logic CPU_IRQ, // Stopwatch request to the CPU
    output logic IRQ // Level interrupt from status/enable
);
    import stopwatch_pkg::*;

    logic [31:0] tick_cnt_r;
    logic [1:0] step_cnt_r;
    logic [6:0] frac_r;
    logic wait_r;
    logic [3:0] hund_r;
    logic [3:0] tenth_r;
    logic run_r;
    logic heavy_r;
    logic [1:0] mask_r;
    logic [1:0] flag_r;
    logic [1:0] sticky_r;
    logic [1:0] irq_en_r;
    logic cpu_ie_r;
    logic irq_r;
    logic cpu_irq_r;
    logic [31:0] rdata_r;
    bus_state_t state_r;

    wire [7:0] idx = AVS_ADDRESS[ADDR_W-1:2];
    wire req = (AVS_READ || AVS_WRITE) && (state_r == BUS_IDLE);
    wire wr = req && AVS_WRITE && AVS_BYTEENABLE[0];
    wire rd = req && AVS_READ;
    wire wr_masks = wr && (idx == IDX_MASKS);
    wire wr_ctl = wr && (idx == IDX_CONTROL);
    wire wr_iclr = wr && (idx == IDX_IRQ_CLEAR);
    wire wr_ien = wr && (idx == IDX_IRQ_ENABLE);
    wire wr_cie = wr && (idx == IDX_CPU_IE);
    wire rd_flags = rd && (idx == IDX_FLAGS);
    wire sw_clear = wr_ctl && AVS_WRITEDATA[BIT_CLEAR];
    wire run_nxt = wr_ctl ? AVS_WRITEDATA[BIT_RUN] : run_r;

    // Time base and step pattern
    wire tick = (tick_cnt_r == TICK_CYCLES - 1);
    // Remainder accumulator spreads the extra ticks: 25 or 26 per decade,
    // exactly 256 per ten decades
    wire [7:0] frac_sum = {1'b0, frac_r} + {1'b0, STEP_FRAC};
    wire long_step = (frac_sum >= {1'b0, STEP_MOD});
    wire [7:0] frac_wrap = frac_sum - {1'b0, STEP_MOD};
    wire [6:0] frac_nxt = long_step ? frac_wrap[6:0] : frac_sum[6:0];
    wire [1:0] step_len = long_step ? STEP_LONG : STEP_SHORT;
    wire step = run_r && tick && (step_cnt_r == step_len - 2'h1);
    wire hund_ovf = step && (hund_r == BCD_MAX);
    wire tenth_ovf = hund_ovf && (tenth_r == BCD_MAX);
    wire [1:0] event_set = {tenth_ovf, hund_ovf};

    wire [3:0] hund_nxt = hund_ovf ? DIGIT_RST : hund_r + 4'h1;
    wire [3:0] tenth_nxt = tenth_ovf ? DIGIT_RST : tenth_r + 4'h1;

    // Set wins over read-clear and write-clear
    wire [1:0] flag_nxt = event_set | (rd_flags ? 2'h0 : flag_r);
    wire [1:0] iclr = wr_iclr ? AVS_WRITEDATA[1:0] : 2'h0;
    wire [1:0] sticky_nxt = event_set | (sticky_r & ~iclr);
    wire [1:0] ien_nxt = wr_ien ? AVS_WRITEDATA[1:0] : irq_en_r;
    wire [1:0] mask_nxt = wr_masks ?
        {AVS_WRITEDATA[BIT_ONEHZ], AVS_WRITEDATA[BIT_TENHZ]} : mask_r;
    wire cie_nxt = wr_cie ? AVS_WRITEDATA[0] : cpu_ie_r;
    wire cpu_irq_nxt = |(flag_nxt & mask_nxt) && cie_nxt;

    logic [31:0] rd_mux;

    // Read data selection
    always_comb
    begin
        rd_mux = UNMAPPED_DATA;
        if (idx == IDX_HUNDREDTHS)
        begin
            rd_mux = {28'h0, hund_r};
        end
        else if (idx == IDX_TENTHS)
        begin
            rd_mux = {28'h0, tenth_r};
        end
        else if (idx == IDX_MASKS)
        begin
            rd_mux = {28'h0, heavy_r, 1'b0, mask_r};
        end
        else if (idx == IDX_FLAGS)
        begin
            rd_mux = {30'h0, flag_r};
        end
        else if (idx == IDX_CONTROL)
        begin
            rd_mux = {29'h0, run_r, 2'h0};
        end
        else if (idx == IDX_IRQ_STATUS)
        begin
            rd_mux = {30'h0, sticky_r};
        end
        else if (idx == IDX_IRQ_ENABLE)
        begin
            rd_mux = {30'h0, irq_en_r};
        end
        else if (idx == IDX_CPU_IE)
        begin
            rd_mux = {31'h0, cpu_ie_r};
        end
    end

    // Time base divider free-runs; the step counter restarts on clear so a running count restarts cleanly
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            tick_cnt_r <= 32'h0;
            step_cnt_r <= 2'h0;
        end
        else if (CLK_EN)
        begin
            tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
            if (sw_clear)
                step_cnt_r <= 2'h0;
            else if (run_r && tick)
                step_cnt_r <= step ? 2'h0 : step_cnt_r + 2'h1;
        end
    end

    // BCD stages
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            hund_r <= DIGIT_RST;
            tenth_r <= DIGIT_RST;
            frac_r <= FRAC_RST;
        end
        else if (CLK_EN)
        begin
            if (sw_clear)
            begin
                hund_r <= DIGIT_RST;
                tenth_r <= DIGIT_RST;
                frac_r <= FRAC_RST;
            end
            else if (step)
            begin
                hund_r <= hund_nxt;
                frac_r <= frac_nxt;
                if (hund_ovf)
                begin
                    tenth_r <= tenth_nxt;
                end
            end
        end
    end

    // Run bit, load mode and masks
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            run_r <= 1'b0;
            heavy_r <= 1'b0;
            mask_r <= MASK_RST;
        end
        else if (CLK_EN)
        begin
            run_r <= run_nxt;
            if (wr_masks)
                heavy_r <= AVS_WRITEDATA[BIT_HEAVY];
            mask_r <= mask_nxt;
        end
    end

    // Factor flags and sticky status
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            flag_r <= 2'h0;
            sticky_r <= 2'h0;
        end
        else if (CLK_EN)
        begin
            flag_r <= flag_nxt;
            sticky_r <= sticky_nxt;
        end
    end

    // Interrupt enables
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            irq_en_r <= 2'h0;
            cpu_ie_r <= 1'b0;
        end
        else if (CLK_EN)
        begin
            irq_en_r <= ien_nxt;
            cpu_ie_r <= cie_nxt;
        end
    end

    // Registered interrupt outputs
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            irq_r <= 1'b0;
            cpu_irq_r <= 1'b0;
        end
        else if (CLK_EN)
        begin
            irq_r <= |(sticky_nxt & ien_nxt);
            cpu_irq_r <= cpu_irq_nxt;
        end
    end

    // Avalon slave: one wait cycle, answer in the second
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            state_r <= BUS_IDLE;
            rdata_r <= 32'h0;
            wait_r <= 1'b1;
        end
        else if (CLK_EN)
        begin
            case (state_r)
                BUS_IDLE:
                begin
                    if (req)
                    begin
                        state_r <= BUS_DONE;
                        rdata_r <= AVS_READ ? rd_mux : 32'h0;
                        wait_r <= 1'b0;
                    end
                end
                BUS_DONE:
                begin
                    state_r <= BUS_IDLE;
                    wait_r <= 1'b1;
                end
                default:
                begin
                    state_r <= BUS_IDLE;
                    wait_r <= 1'b1;
                end
            endcase
        end
    end

    assign AVS_READDATA = rdata_r;
    assign AVS_WAITREQUEST = wait_r;
    assign HEAVY_LOAD_SELECT = heavy_r;
    assign IRQ = irq_r;
    assign CPU_IRQ = cpu_irq_r;

endmodule

/* File: bcd_stopwatch_timer_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
    error_cnt++; $display("unexpected %s exp %h got %h", n, e, a); end end
module bcd_stopwatch_timer_tb;
    import stopwatch_pkg::*;
    localparam int TCK = 4;
    logic ref_clk = 1'b0, srst = 1'b1, clk_en = 1'b1, rd_en = 1'b0;
    logic wr_en = 1'b0, cpu_irq, irq, wait_req;
    logic [9:0] addr = 10'h0;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [3:0] be = 4'hF, h;
    logic [7:0] regs [8] = '{IDX_HUNDREDTHS, IDX_TENTHS, IDX_MASKS,
        IDX_FLAGS, IDX_CONTROL, IDX_IRQ_STATUS, IDX_CPU_IE, 8'h3F};
    int error_cnt = 0, n_compared = 0;
    bcd_stopwatch_timer #(.TICK_CYCLES(TCK)) uut (.REF_CLK(ref_clk),
        .SRST(srst), .CLK_EN(clk_en), .AVS_ADDRESS(addr), .AVS_READ(rd_en),
        .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
        .HEAVY_LOAD_SELECT(), .CPU_IRQ(cpu_irq), .IRQ(irq));
    always #2.5 ref_clk = ~ref_clk;
    task automatic end_sim();
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One bus cycle, entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] d);
        int k;
        addr <= {a, 2'b00};
        wdata <= {28'h0, d};
        rd_en <= !w;
        wr_en <= w;
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
        end while (wait_req !== 1'b0 && k < 50);
        q = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        if (k >= 50)
        begin
            error_cnt++;
            end_sim();
        end
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [3:0] e);
        bus(1'b0, a, 4'h0);
        `CHK($sformatf("reg %h", a), {28'h0, e}, q)
    endtask
    task automatic sig(input logic ec, input logic ei);
        @(negedge ref_clk);
        `CHK("cpu_irq", ec, cpu_irq)
        `CHK("irq", ei, irq)
        @(posedge ref_clk);
    endtask
    initial
    begin
        void'($urandom(35137));
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        foreach (regs[i]) rd(regs[i], 4'h0);
        wr(IDX_CPU_IE, 4'h1);
        wr(IDX_CONTROL, 4'h4);
        rd(IDX_CONTROL, 4'h4);
        repeat (300 * TCK) @(posedge ref_clk);
        wr(IDX_CONTROL, 4'h0);
        sig(1'b0, 1'b0);
        wr(IDX_MASKS, 4'h3);
        rd(IDX_MASKS, 4'h3);
        sig(1'b1, 1'b0);
        wr(IDX_IRQ_ENABLE, 4'h3);
        sig(1'b1, 1'b1);
        wr(IDX_IRQ_CLEAR, 4'h3);
        sig(1'b1, 1'b0);
        rd(IDX_FLAGS, 4'h3);
        sig(1'b0, 1'b0);
        rd(IDX_FLAGS, 4'h0);
        rd(IDX_TENTHS, 4'h1);
        bus(1'b0, IDX_HUNDREDTHS, 4'h0);
        h = q[3:0];
        `CHK("hundredths", 1'b1, h >= 4'h6 && h <= 4'h8)
        wr(IDX_HUNDREDTHS, 4'($urandom));
        wr(IDX_FLAGS, 4'hF);
        be <= 4'hE;
        wr(IDX_MASKS, 4'h0);
        be <= 4'hF;
        repeat ($urandom_range(20, 60) * TCK) @(posedge ref_clk);
        rd(IDX_HUNDREDTHS, h);
        rd(IDX_TENTHS, 4'h1);
        rd(IDX_FLAGS, 4'h0);
        rd(IDX_MASKS, 4'h3);
        wr(IDX_MASKS, 4'h0);
        wr(IDX_CPU_IE, 4'h0);
        wr(IDX_CONTROL, 4'h2);
        repeat (30 * TCK) @(posedge ref_clk);
        foreach (regs[i]) rd(regs[i], 4'h0);
        wr(IDX_CONTROL, 4'h4);
        repeat (40 * TCK) @(posedge ref_clk);
        wr(IDX_CONTROL, 4'h6);
        rd(IDX_CONTROL, 4'h4);
        repeat (10 * TCK) @(posedge ref_clk);
        wr(IDX_CONTROL, 4'h0);
        rd(IDX_TENTHS, 4'h0);
        bus(1'b0, IDX_HUNDREDTHS, 4'h0);
        `CHK("restart", 1'b1, q[3:0] >= 4'h3 && q[3:0] <= 4'h5)
        end_sim();
    end
endmodule

/* File: stopwatch_assertions.sv */
`timescale 1ns/1ps
module stopwatch_assertions
    import stopwatch_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_DIV
)
(
    input wire logic REF_CLK, // Clock
    input wire logic SRST, // Reset
    input wire logic CLK_EN, // Enable
    input wire logic [stopwatch_pkg::ADDR_W-1:0] AVS_ADDRESS, // Address
    input wire logic AVS_READ, // Read
    input wire logic AVS_WRITE, // Write
    input wire logic [31:0] AVS_WRITEDATA, // Write data
    input wire logic [3:0] AVS_BYTEENABLE, // Byte enables
    input wire logic [31:0] AVS_READDATA, // Read data
    input wire logic AVS_WAITREQUEST, // Wait
    input wire logic HEAVY_LOAD_SELECT, // Load mode
    input wire logic CPU_IRQ, // CPU request
    input wire logic IRQ // Interrupt
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    logic run_r;
    logic [1:0] msk_r;
    wire [7:0] ix = AVS_ADDRESS[9:2];
    wire tk = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST & CLK_EN;
    wire wr_ok = tk & AVS_WRITE & AVS_BYTEENABLE[0];
    wire ans = !AVS_WAITREQUEST & AVS_READ;
    // Last written run bit and masks, as software sees them
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            run_r <= 1'b0;
            msk_r <= 2'h0;
        end
        else
        begin
            if (wr_ok && ix == IDX_CONTROL) run_r <= AVS_WRITEDATA[BIT_RUN];
            if (wr_ok && ix == IDX_MASKS) msk_r <= AVS_WRITEDATA[1:0];
        end
    end
    sequence s_answer;
        !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence
    AST_ANSWER_ONE: assert property (tk |=> s_answer)
        else $error("request not answered after one cycle");
    AST_DIGIT_BCD: assert property (ans && (ix == IDX_HUNDREDTHS ||
        ix == IDX_TENTHS) |-> AVS_READDATA <= 32'h9)
        else $error("digit read is not BCD");
    AST_CLEAR_READS_ZERO: assert property (ans && ix == IDX_CONTROL
        |-> AVS_READDATA[BIT_CLEAR] == 1'b0) else $error("clear bit read one");
    AST_RUN_READBACK: assert property (ans && ix == IDX_CONTROL
        |-> AVS_READDATA[BIT_RUN] == run_r) else $error("run bit readback");
    AST_MASK_READBACK: assert property (ans && ix == IDX_MASKS
        |-> AVS_READDATA[1:0] == msk_r) else $error("mask readback");
    AST_FLAG_WORD: assert property (ans && ix == IDX_FLAGS
        |-> AVS_READDATA[31:2] == 30'h0) else $error("flag word upper bits");
    AST_MASK_GATES: assert property (wr_ok && ix == IDX_MASKS &&
        AVS_WRITEDATA[1:0] == 2'h0 |-> ##[2:3] !CPU_IRQ)
        else $error("request while masked");
    AST_CPU_IE_GATES: assert property (wr_ok && ix == IDX_CPU_IE &&
        !AVS_WRITEDATA[0] |-> ##[2:3] !CPU_IRQ)
        else $error("request while cpu interrupts off");
endmodule
bind bcd_stopwatch_timer stopwatch_assertions #(.TICK_CYCLES(TICK_CYCLES))
    u_chk (.REF_CLK(REF_CLK), .SRST(SRST), .CLK_EN(CLK_EN),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .HEAVY_LOAD_SELECT(HEAVY_LOAD_SELECT), .CPU_IRQ(CPU_IRQ), .IRQ(IRQ));

/* File: stopwatch_pkg.sv */
package stopwatch_pkg;

    // Register word indexes (printed offsets are not all word aligned,
    // so the printed offset is the index and the byte address is 4x it)
    localparam logic [7:0] IDX_HUNDREDTHS = 8'h71;
    localparam logic [7:0] IDX_TENTHS = 8'h72;
    localparam logic [7:0] IDX_MASKS = 8'h76;
    localparam logic [7:0] IDX_FLAGS = 8'h7A;
    localparam logic [7:0] IDX_CONTROL = 8'h7E;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h80;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'h81;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h82;
    localparam logic [7:0] IDX_CPU_IE = 8'h83;
    localparam int ADDR_W = 10;

    // Field positions
    localparam int BIT_TENHZ = 0;
    localparam int BIT_ONEHZ = 1;
    localparam int BIT_CLEAR = 1;
    localparam int BIT_RUN = 2;
    localparam int BIT_HEAVY = 3;
    localparam int BIT_PORT0_DIR = 0;
    localparam int BIT_CLK_TMR_CLR = 3;

    // Reset values, BCD digit limit and unmapped read data
    localparam logic [3:0] DIGIT_RST = 4'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // Time base: 256 Hz tick from the 200 MHz reference
    localparam longint REF_CLK_HZ = 200_000_000;
    localparam longint TICK_HZ = 256;
    localparam int TICK_DIV = int'(REF_CLK_HZ / TICK_HZ);

    // Hundredths step pattern: 2 or 3 ticks per count, 3 when the remainder
    // accumulator wraps, so decade overflows are 25 or 26 ticks
    localparam logic [1:0] STEP_SHORT = 2'h2;
    localparam logic [1:0] STEP_LONG = 2'h3;
    // 256 ticks per 100 steps: 2 ticks each plus a 56/100 remainder
    localparam logic [6:0] STEP_FRAC = 7'h38;
    localparam logic [6:0] STEP_MOD = 7'h64;
    localparam logic [6:0] FRAC_RST = 7'h00;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DONE = 2'b10
    } bus_state_t;

endpackage
